// file: adaptive_clock_generator.sv
// phase accumulator; output toggles at freq_value * f_clk / 2^W
module adaptive_clock_generator #(
  parameter int W = 24
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] freq_value_i,
  output logic clk_out_o
);
  logic [W-1:0] acc_ff;
  logic [W-1:0] nxt_acc;

  // wraps on purpose, the carry is the phase
  assign nxt_acc = acc_ff + freq_value_i;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // msb as square wave; jitter is one clock period, traded for no fractional divider
  assign clk_out_o = acc_ff[W-1];
endmodule

// file: codec_partner.sv
module codec_partner (
  input wire logic run_i,
  output logic ext_mclk_o,
  output logic [5:0] drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bit_clock;
  logic [7:0] pat;
  // bit clock stands still outside frames
  initial begin
    bit_clock = 1'b0;
    forever #100 bit_clock = run_i ? ~bit_clock : bit_clock;
  end
  // codec runs from the shared external master clock
  initial begin
    ext_mclk_o = 1'b0;
    forever #75 ext_mclk_o = ~ext_mclk_o;
  end
  initial pat = 8'h5a;
  always @(negedge bit_clock) begin
    pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
  end
  // order aux,rst,din,dout,sclk,sync; bench muxes by device enables
  assign drive_o = {pat[4:1], bit_clock, pat[0]};
endmodule

// file: codec_pin_mux_consts.svh
`ifndef CODEC_PIN_MUX_CONSTS_SVH
`define CODEC_PIN_MUX_CONSTS_SVH

// reference clock
`define REF_CLK_MHZ 40
`define REF_CLK_PERIOD_NS 25

// register byte addresses
`define ADDR_W 4
`define CFG_ONE_ADDR 4'h0
`define ADAPT_FREQ_ADDR 4'h4
`define ADAPT_MEAS_ADDR 4'h8
`define GP_PIN_ADDR 4'hc

// codec_port_config_one fields
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 2
`define CFG_SYNC_OUT_BIT 3
`define CFG_SCLK_OUT_BIT 4
`define CFG_EXT_MCLK_BIT 5
`define CFG_CTRL_FLAG_BIT 6
`define CFG_W 7
`define CFG_RESET 7'h00

// adaptive clock generator
`define ADAPT_FREQ_W 24
`define ADAPT_FREQ_RESET 24'h400000
`define MEAS_W 16
`define MEAS_WINDOW_US 1000

// gp pin register: outputs in [4:0], synced pin levels in [13:8]
`define GP_OUT_W 5
`define GP_OUT_RESET 5'h00
`define GP_IN_LSB 8

// pin index in the six-terminal vectors
`define PIN_SYNC 0
`define PIN_SCLK 1
`define PIN_DOUT 2
`define PIN_DIN 3
`define PIN_RST 4
`define PIN_AUX 5
`define PIN_COUNT 6

// output enable per mode, bit order aux,rst,din,dout,sclk,sync
`define OE_MODE0_FIXED 6'h34
`define OE_MODE1 6'h37
`define OE_MODE2 6'h35
`define OE_MODE3 6'h15
`define OE_MODE4 6'h1f
`define OE_MODE5 6'h0f
`define OE_MODE6 6'h07
`define OE_MODE7 6'h3f

`endif

// file: codec_pin_mux_pkg.sv
package codec_pin_mux_pkg;
  typedef enum logic [2:0] {
    MODE_GP = 3'h0,
    MODE_SERIAL_CODEC = 3'h1,
    MODE_AC97_V1 = 3'h2,
    MODE_AC97_V2 = 3'h3,
    MODE_I2S_3OUT = 3'h4,
    MODE_I2S_2OUT = 3'h5,
    MODE_I2S_1OUT = 3'h6,
    MODE_I2S_4OUT = 3'h7
  } codec_mode_t;
endpackage

// file: codec_port_pin_mux.sv
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`include "codec_pin_mux_consts.svh"

// Overview of operation
// - the mode field of codec_port_config_one selects one of eight codec port modes.
// - mode 0 drives data-out and reset, reads data-in and leaves the aux pin without a function.
// - only in mode 0 may software set the sync and serial clock pins as inputs or outputs.
// - a pin with no function in the current mode is still driven as an output.
// - mode 1 drives frame sync, serial clock, data out, reset and a control flag on aux, and reads data in.
// - AC'97 modes 2 and 3 drive sync, data out and reset and read bit clock and data in, mode 3 also reads aux.
// - I2S modes 4 to 7 drive LR clock and serial clock, with three, two, one or four data outputs.
// - for rate-locked operation the port and codec both run from the adaptive master clock.
// - the adaptive clock generator makes its clock at a rate set by a software frequency value.
// - software can read back a measure of the adaptive clock rate to retune it.
// - the port can instead run from an external master clock input.
// - the port master clock and serial clock are made apart from the general clock generator.
// - the adaptive clock generator is derived from the base clock.
module codec_port_pin_mux #(
  parameter int MEAS_WINDOW_CYCLES = `MEAS_WINDOW_US * `REF_CLK_MHZ
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [`ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic codec_sync_pin_i,
  output logic codec_sync_pin_o,
  output logic codec_sync_pin_oe_o,
  input wire logic codec_serial_clock_pin_i,
  output logic codec_serial_clock_pin_o,
  output logic codec_serial_clock_pin_oe_o,
  input wire logic codec_data_out_pin_i,
  output logic codec_data_out_pin_o,
  output logic codec_data_out_pin_oe_o,
  input wire logic codec_data_in_pin_i,
  output logic codec_data_in_pin_o,
  output logic codec_data_in_pin_oe_o,
  input wire logic codec_reset_pin_i,
  output logic codec_reset_pin_o,
  output logic codec_reset_pin_oe_o,
  input wire logic codec_aux_pin_i,
  output logic codec_aux_pin_o,
  output logic codec_aux_pin_oe_o,
  input wire logic external_master_clock_in_i,
  output logic adaptive_master_clock_out_o,
  output logic port_master_clock_o,
  input wire logic eng_frame_sync_i,
  input wire logic eng_serial_clock_i,
  input wire logic [3:0] eng_data_out_i,
  input wire logic eng_codec_reset_i,
  output logic [2:0] eng_data_in_o,
  output logic eng_bit_clock_rise_o
);
  localparam int PN = `PIN_COUNT;

  // registers
  logic [`CFG_W-1:0] cfg_ff;
  logic [`ADAPT_FREQ_W-1:0] freq_ff;
  logic [`GP_OUT_W-1:0] gp_out_ff;
  logic [`MEAS_W-1:0] meas_ff;
  logic [`MEAS_W-1:0] edge_cnt_ff;
  logic [`MEAS_W-1:0] win_cnt_ff;
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic [PN-1:0] pin_out_ff;
  logic [PN-1:0] pin_oe_ff;
  logic [PN:0] sync1_ff;
  logic [PN:0] sync2_ff;
  logic sclk_prev_ff;
  logic adapt_prev_ff;
  logic adapt_out_ff;
  logic port_mclk_ff;
  logic [2:0] din_ff;
  logic bclk_rise_ff;

  // next values
  logic [`CFG_W-1:0] nxt_cfg;
  logic [`ADAPT_FREQ_W-1:0] nxt_freq;
  logic [`GP_OUT_W-1:0] nxt_gp_out;
  logic [`MEAS_W-1:0] nxt_meas;
  logic [`MEAS_W-1:0] nxt_edge_cnt;
  logic [`MEAS_W-1:0] nxt_win_cnt;
  logic nxt_waitreq;
  logic [31:0] nxt_rdata;
  logic [PN-1:0] nxt_pin_out;
  logic [PN-1:0] nxt_pin_oe;
  logic [2:0] nxt_din;

  // decode
  codec_pin_mux_pkg::codec_mode_t mode;
  wire acc_go = (avs_read_i | avs_write_i) & waitreq_ff;
  wire wr_go = avs_write_i & ~waitreq_ff;
  wire wr_cfg = wr_go & (avs_address_i == `CFG_ONE_ADDR);
  wire wr_freq = wr_go & (avs_address_i == `ADAPT_FREQ_ADDR);
  wire wr_gp = wr_go & (avs_address_i == `GP_PIN_ADDR);
  wire [PN-1:0] pin_in = sync2_ff[PN-1:0];
  wire ext_mclk = sync2_ff[PN];
  wire adapt_clk;
  wire win_end = (win_cnt_ff == MEAS_WINDOW_CYCLES[`MEAS_W-1:0] - 16'h0001);
  wire adapt_rise = adapt_out_ff & ~adapt_prev_ff;
  wire sync_out_en = cfg_ff[`CFG_SYNC_OUT_BIT];
  wire sclk_out_en = cfg_ff[`CFG_SCLK_OUT_BIT];

  assign mode = codec_pin_mux_pkg::codec_mode_t'(cfg_ff[`CFG_MODE_MSB:`CFG_MODE_LSB]);

  // direction map; unused pins stay outputs
  function automatic logic [PN-1:0] oe_map(input codec_pin_mux_pkg::codec_mode_t m, input logic s_out,
                                           input logic c_out);
    case (m)
      codec_pin_mux_pkg::MODE_GP: oe_map = `OE_MODE0_FIXED | {4'h0, c_out, s_out};
      codec_pin_mux_pkg::MODE_SERIAL_CODEC: oe_map = `OE_MODE1;
      codec_pin_mux_pkg::MODE_AC97_V1: oe_map = `OE_MODE2;
      codec_pin_mux_pkg::MODE_AC97_V2: oe_map = `OE_MODE3;
      codec_pin_mux_pkg::MODE_I2S_3OUT: oe_map = `OE_MODE4;
      codec_pin_mux_pkg::MODE_I2S_2OUT: oe_map = `OE_MODE5;
      codec_pin_mux_pkg::MODE_I2S_1OUT: oe_map = `OE_MODE6;
      codec_pin_mux_pkg::MODE_I2S_4OUT: oe_map = `OE_MODE7;
      default: oe_map = `OE_MODE7;
    endcase
  endfunction

  // pin output values; pins without a function drive low
  wire is_gp = (mode == codec_pin_mux_pkg::MODE_GP);
  wire is_i2s = mode[2];
  wire is_ac97 = (mode == codec_pin_mux_pkg::MODE_AC97_V1) | (mode == codec_pin_mux_pkg::MODE_AC97_V2);
  wire is_sc = (mode == codec_pin_mux_pkg::MODE_SERIAL_CODEC);
  wire din_is_out = (mode == codec_pin_mux_pkg::MODE_I2S_3OUT) | (mode == codec_pin_mux_pkg::MODE_I2S_4OUT);
  // mode 5 drives data-in too, as its second data output
  wire din_drives = din_is_out | (mode == codec_pin_mux_pkg::MODE_I2S_2OUT);
  wire out_sync = is_gp ? gp_out_ff[`PIN_SYNC] : eng_frame_sync_i;
  wire out_sclk = is_gp ? gp_out_ff[`PIN_SCLK] : (is_ac97 ? 1'b0 : eng_serial_clock_i);
  wire out_dout = is_gp ? gp_out_ff[`PIN_DOUT] : eng_data_out_i[0];
  wire out_din = din_drives & eng_data_out_i[1];
  wire out_rst = is_gp ? gp_out_ff[`PIN_RST] : (din_is_out ? eng_data_out_i[2] : (~is_i2s & eng_codec_reset_i));
  wire out_aux = is_sc ? cfg_ff[`CFG_CTRL_FLAG_BIT] :
                 ((mode == codec_pin_mux_pkg::MODE_I2S_4OUT) & eng_data_out_i[3]);

  assign nxt_pin_out = {out_aux, out_rst, out_din, out_dout, out_sclk, out_sync};
  assign nxt_pin_oe = oe_map(mode, sync_out_en, sclk_out_en);

  // serial data inputs routed to the engine
  wire in1 = (mode == codec_pin_mux_pkg::MODE_I2S_3OUT) ? pin_in[`PIN_AUX] :
             (mode == codec_pin_mux_pkg::MODE_I2S_2OUT) ? pin_in[`PIN_RST] :
             (mode == codec_pin_mux_pkg::MODE_I2S_4OUT) ? 1'b0 : pin_in[`PIN_DIN];
  wire in2 = (mode == codec_pin_mux_pkg::MODE_AC97_V2) ? pin_in[`PIN_AUX] :
             (mode == codec_pin_mux_pkg::MODE_I2S_2OUT) ? pin_in[`PIN_AUX] :
             (mode == codec_pin_mux_pkg::MODE_I2S_1OUT) ? pin_in[`PIN_RST] : 1'b0;
  wire in3 = (mode == codec_pin_mux_pkg::MODE_I2S_1OUT) & pin_in[`PIN_AUX];
  assign nxt_din = {in3, in2, in1};

  // register writes
  assign nxt_cfg = wr_cfg ? avs_writedata_i[`CFG_W-1:0] : cfg_ff;
  assign nxt_freq = wr_freq ? avs_writedata_i[`ADAPT_FREQ_W-1:0] : freq_ff;
  assign nxt_gp_out = wr_gp ? avs_writedata_i[`GP_OUT_W-1:0] : gp_out_ff;

  // one wait state on every access
  assign nxt_waitreq = ~acc_go;

  wire [31:0] rd_cfg = {{(32-`CFG_W){1'b0}}, cfg_ff};
  wire [31:0] rd_freq = {{(32-`ADAPT_FREQ_W){1'b0}}, freq_ff};
  wire [31:0] rd_meas = {{(32-`MEAS_W){1'b0}}, meas_ff};
  wire [31:0] rd_gp = {18'h00000, pin_in, 3'h0, gp_out_ff};
  assign nxt_rdata = ~(avs_read_i & acc_go) ? rdata_ff :
                     (avs_address_i == `CFG_ONE_ADDR) ? rd_cfg :
                     (avs_address_i == `ADAPT_FREQ_ADDR) ? rd_freq :
                     (avs_address_i == `ADAPT_MEAS_ADDR) ? rd_meas :
                     (avs_address_i == `GP_PIN_ADDR) ? rd_gp : 32'h00000000;

  // rising edges of the adaptive clock counted over a fixed window
  assign nxt_win_cnt = win_end ? 16'h0000 : win_cnt_ff + 16'h0001;
  assign nxt_edge_cnt = win_end ? 16'h0000 : edge_cnt_ff + {15'h0000, adapt_rise};
  assign nxt_meas = win_end ? edge_cnt_ff + {15'h0000, adapt_rise} : meas_ff;

  // adaptive clock made from the base clock by its own accumulator
  adaptive_clock_generator #(
    .W(`ADAPT_FREQ_W)
  ) u_adapt (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .freq_value_i(freq_ff),
    .clk_out_o(adapt_clk)
  );

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_ff <= `CFG_RESET;
      freq_ff <= `ADAPT_FREQ_RESET;
      gp_out_ff <= `GP_OUT_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
      freq_ff <= nxt_freq;
      gp_out_ff <= nxt_gp_out;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waitreq_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      waitreq_ff <= nxt_waitreq;
      rdata_ff <= nxt_rdata;
    end
  end

  // reset state is mode 0, aux, reset and data-out driven, sync, serial clock and data-in undriven
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_ff <= 6'h00;
      pin_oe_ff <= `OE_MODE0_FIXED;
      din_ff <= 3'h0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      din_ff <= nxt_din;
    end
  end

  // pin and external clock levels are asynchronous here
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
      sclk_prev_ff <= 1'b0;
      bclk_rise_ff <= 1'b0;
    end else begin
      sync1_ff <= {external_master_clock_in_i, codec_aux_pin_i, codec_reset_pin_i, codec_data_in_pin_i,
                   codec_data_out_pin_i, codec_serial_clock_pin_i, codec_sync_pin_i};
      sync2_ff <= sync1_ff;
      sclk_prev_ff <= pin_in[`PIN_SCLK];
      bclk_rise_ff <= pin_in[`PIN_SCLK] & ~sclk_prev_ff & ~pin_oe_ff[`PIN_SCLK];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adapt_out_ff <= 1'b0;
      adapt_prev_ff <= 1'b0;
      port_mclk_ff <= 1'b0;
      win_cnt_ff <= 16'h0000;
      edge_cnt_ff <= 16'h0000;
      meas_ff <= 16'h0000;
    end else begin
      adapt_out_ff <= adapt_clk;
      adapt_prev_ff <= adapt_out_ff;
      port_mclk_ff <= cfg_ff[`CFG_EXT_MCLK_BIT] ? ext_mclk : adapt_clk;
      win_cnt_ff <= nxt_win_cnt;
      edge_cnt_ff <= nxt_edge_cnt;
      meas_ff <= nxt_meas;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = waitreq_ff;
  assign codec_sync_pin_o = pin_out_ff[`PIN_SYNC];
  assign codec_sync_pin_oe_o = pin_oe_ff[`PIN_SYNC];
  assign codec_serial_clock_pin_o = pin_out_ff[`PIN_SCLK];
  assign codec_serial_clock_pin_oe_o = pin_oe_ff[`PIN_SCLK];
  assign codec_data_out_pin_o = pin_out_ff[`PIN_DOUT];
  assign codec_data_out_pin_oe_o = pin_oe_ff[`PIN_DOUT];
  assign codec_data_in_pin_o = pin_out_ff[`PIN_DIN];
  assign codec_data_in_pin_oe_o = pin_oe_ff[`PIN_DIN];
  assign codec_reset_pin_o = pin_out_ff[`PIN_RST];
  assign codec_reset_pin_oe_o = pin_oe_ff[`PIN_RST];
  assign codec_aux_pin_o = pin_out_ff[`PIN_AUX];
  assign codec_aux_pin_oe_o = pin_oe_ff[`PIN_AUX];
  assign adaptive_master_clock_out_o = adapt_out_ff;
  assign port_master_clock_o = port_mclk_ff;
  assign eng_data_in_o = din_ff;
  assign eng_bit_clock_rise_o = bclk_rise_ff;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_cfg_write_mode: assert property (
    wr_cfg |=> (cfg_ff[2:0] == $past(avs_writedata_i[2:0])) ##1 (pin_oe_ff == oe_map(mode, sync_out_en, sclk_out_en)))
    else $error("mode write not taken into direction map");
  a_gp_directions: assert property (
    (mode == codec_pin_mux_pkg::MODE_GP) && $stable(cfg_ff) |=> pin_oe_ff[5:2] == 4'hd)
    else $error("mode 0 fixed directions wrong");
  a_gp_sync_dir: assert property (
    (mode == codec_pin_mux_pkg::MODE_GP) && $stable(cfg_ff) |=> pin_oe_ff[1:0] == $past({sclk_out_en, sync_out_en}))
    else $error("mode 0 sync or sclk direction not from config");
  a_nc_driven: assert property (
    (mode == codec_pin_mux_pkg::MODE_AC97_V1) && $stable(cfg_ff) |=> pin_oe_ff[`PIN_AUX] && pin_out_ff[`PIN_AUX] == 1'b0)
    else $error("unused aux pin not driven low");
  a_mode1_flag: assert property (
    is_sc && $stable(cfg_ff) |=> pin_oe_ff == `OE_MODE1 && pin_out_ff[`PIN_AUX] == $past(cfg_ff[`CFG_CTRL_FLAG_BIT]))
    else $error("mode 1 control flag or directions wrong");
  a_ac97_bitclk: assert property (
    is_ac97 && $stable(cfg_ff) |=> !pin_oe_ff[`PIN_SCLK] && !pin_oe_ff[`PIN_DIN])
    else $error("AC97 bit clock or data in driven");
  a_i2s_clocks: assert property (
    is_i2s && $stable(cfg_ff) |=> pin_oe_ff[1:0] == 2'h3)
    else $error("I2S clocks not driven");
  a_mclk_select: assert property (
    cfg_ff[`CFG_EXT_MCLK_BIT] && $stable(cfg_ff) |=> port_mclk_ff == $past(sync2_ff[PN]))
    else $error("external master clock not selected");
  a_mclk_adaptive: assert property (
    !cfg_ff[`CFG_EXT_MCLK_BIT] && $stable(cfg_ff) |=> port_mclk_ff == adaptive_master_clock_out_o)
    else $error("port clock not the adaptive clock");
  a_meas_latch: assert property (
    win_end |=> meas_ff == $past(edge_cnt_ff) + {15'h0000, $past(adapt_rise)} && edge_cnt_ff == 16'h0000)
    else $error("clock measure not latched at window end");
  a_oe_follows: assert property (
    $changed(cfg_ff[2:0]) |-> ##1 pin_oe_ff == oe_map($past(mode), $past(sync_out_en), $past(sclk_out_en)))
    else $error("output enables lag the mode");
  a_i2s_three_out: assert property (
    mode == codec_pin_mux_pkg::MODE_I2S_3OUT && $stable(cfg_ff) |=>
      pin_oe_ff == `OE_MODE4 && din_ff[0] == $past(pin_in[`PIN_AUX]))
    else $error("mode 4 directions or data input wrong");
  a_i2s_two_out: assert property (
    mode == codec_pin_mux_pkg::MODE_I2S_2OUT && $stable(cfg_ff) |=>
      pin_oe_ff == `OE_MODE5 && pin_out_ff[`PIN_DIN] == $past(eng_data_out_i[1]))
    else $error("mode 5 second data output wrong");
  a_i2s_one_out: assert property (
    mode == codec_pin_mux_pkg::MODE_I2S_1OUT && $stable(cfg_ff) |=>
      pin_oe_ff == `OE_MODE6 && din_ff == $past({pin_in[`PIN_AUX], pin_in[`PIN_RST], pin_in[`PIN_DIN]}))
    else $error("mode 6 data inputs wrong");
  a_i2s_four_out: assert property (
    mode == codec_pin_mux_pkg::MODE_I2S_4OUT && $stable(cfg_ff) |=>
      pin_oe_ff == `OE_MODE7 && pin_out_ff[`PIN_AUX] == $past(eng_data_out_i[3]) && din_ff == 3'h0)
    else $error("mode 7 outputs wrong");
  a_ac97_aux_in: assert property (
    mode == codec_pin_mux_pkg::MODE_AC97_V2 && $stable(cfg_ff) |=>
      pin_oe_ff == `OE_MODE3 && din_ff[1] == $past(pin_in[`PIN_AUX]))
    else $error("mode 3 second data input wrong");
  a_gp_out_drive: assert property (
    is_gp && $stable(cfg_ff) |=>
      pin_out_ff[`PIN_DOUT] == $past(gp_out_ff[`PIN_DOUT]) && pin_out_ff[`PIN_RST] == $past(gp_out_ff[`PIN_RST]))
    else $error("mode 0 output values wrong");
  a_bus_one_wait: assert property (
    acc_go |=> !waitreq_ff ##1 waitreq_ff)
    else $error("register access not answered after one wait state");
  a_bclk_one_cycle: assert property (
    bclk_rise_ff |=> !bclk_rise_ff)
    else $error("bit clock rise pulse longer than one cycle");

  c_mode3: cover property (wr_cfg && avs_writedata_i[2:0] == 3'h3);
  c_mode6: cover property (mode == codec_pin_mux_pkg::MODE_I2S_1OUT ##1 mode == codec_pin_mux_pkg::MODE_I2S_4OUT);
  c_meas: cover property (win_end && edge_cnt_ff != 16'h0000);
  c_bclk: cover property (bclk_rise_ff && is_ac97);
  c_mode5: cover property (mode == codec_pin_mux_pkg::MODE_I2S_2OUT && pin_out_ff[`PIN_DIN]);
endmodule

// file: codec_port_pin_mux_bench.sv
`include "codec_pin_mux_consts.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end

module codec_port_pin_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  int failures = 0;
  int cmp_count = 0;
  int cnt[5];
  logic ref_clk, resetn, rd, wr, run, frm_sync, sck, rst_e, wait_req, mclk_a, mclk_p, ext, pulse;
  logic [3:0] addr, eng_do;
  logic [31:0] wdata, rdata, q, seed;
  logic [5:0] dev_o, dev_oe, cod, wire_v;
  logic [2:0] din_e, m;
  logic [6:0] c;
  logic [23:0] f;
  assign wire_v = (dev_oe & dev_o) | (~dev_oe & cod);

  codec_port_pin_mux #(.MEAS_WINDOW_CYCLES(64)) i_dut (
    .ref_clk_i(ref_clk), .resetn_i(resetn), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .codec_sync_pin_i(wire_v[`PIN_SYNC]), .codec_sync_pin_o(dev_o[`PIN_SYNC]),
    .codec_sync_pin_oe_o(dev_oe[`PIN_SYNC]), .codec_serial_clock_pin_i(wire_v[`PIN_SCLK]),
    .codec_serial_clock_pin_o(dev_o[`PIN_SCLK]), .codec_serial_clock_pin_oe_o(dev_oe[`PIN_SCLK]),
    .codec_data_out_pin_i(wire_v[`PIN_DOUT]), .codec_data_out_pin_o(dev_o[`PIN_DOUT]),
    .codec_data_out_pin_oe_o(dev_oe[`PIN_DOUT]), .codec_data_in_pin_i(wire_v[`PIN_DIN]),
    .codec_data_in_pin_o(dev_o[`PIN_DIN]), .codec_data_in_pin_oe_o(dev_oe[`PIN_DIN]),
    .codec_reset_pin_i(wire_v[`PIN_RST]), .codec_reset_pin_o(dev_o[`PIN_RST]),
    .codec_reset_pin_oe_o(dev_oe[`PIN_RST]), .codec_aux_pin_i(wire_v[`PIN_AUX]),
    .codec_aux_pin_o(dev_o[`PIN_AUX]), .codec_aux_pin_oe_o(dev_oe[`PIN_AUX]),
    .external_master_clock_in_i(ext), .adaptive_master_clock_out_o(mclk_a), .port_master_clock_o(mclk_p),
    .eng_frame_sync_i(frm_sync), .eng_serial_clock_i(sck), .eng_data_out_i(eng_do), .eng_codec_reset_i(rst_e),
    .eng_data_in_o(din_e), .eng_bit_clock_rise_o(pulse));

  codec_partner i_link (.run_i(run), .ext_mclk_o(ext), .drive_o(cod));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic bit near(input longint a, input longint b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction

  // enables in order aux,rst,din,dout,sclk,sync
  function automatic logic [5:0] exp_oe(input logic [6:0] v);
    case (v[2:0])
      3'h0: return {4'hd, v[4], v[3]};
      3'h1: return 6'h37;
      3'h2: return 6'h35;
      3'h3: return 6'h15;
      3'h4: return 6'h1f;
      3'h5: return 6'h0f;
      3'h6: return 6'h07;
      default: return 6'h3f;
    endcase
  endfunction

  function automatic logic [2:0] exp_in(input logic [2:0] md, input logic [5:0] w);
    exp_in[0] = (md == 3'h4) ? w[`PIN_AUX] : (md == 3'h5) ? w[`PIN_RST] : (md == 3'h7) ? 1'b0 : w[`PIN_DIN];
    exp_in[1] = (md == 3'h3 || md == 3'h5) ? w[`PIN_AUX] : (md == 3'h6) ? w[`PIN_RST] : 1'b0;
    exp_in[2] = (md == 3'h6) ? w[`PIN_AUX] : 1'b0;
  endfunction

  // waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // counts rises of adaptive, port, external and bit clocks, plus rise pulses
  task automatic count(input int n);
    logic [3:0] pv, cv;
    pv = {mclk_a, mclk_p, ext, cod[`PIN_SCLK]};
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge ref_clk);
      cv = {mclk_a, mclk_p, ext, cod[`PIN_SCLK]};
      for (int k = 0; k < 4; k++) cnt[k] += int'(cv[k] & ~pv[k]);
      cnt[4] += int'(pulse);
      pv = cv;
    end
  endtask

  task final_report;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    final_report;
  end

  initial begin
    {resetn, rd, wr, run, frm_sync, sck, rst_e, eng_do, addr, wdata} = '0;
    seed = 32'h4eaf;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    `CHK("oe_rst", exp_oe(7'h00), dev_oe)
    bus(1'b0, `CFG_ONE_ADDR, 32'h0);
    `CHK("cfg_rst", 32'h0, q)
    bus(1'b0, `ADAPT_FREQ_ADDR, 32'h0);
    `CHK("freq_rst", {8'h0, `ADAPT_FREQ_RESET}, q)
    bus(1'b1, 4'h2, 32'hffffffff);
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, q)
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      c = seed[6:0];
      if (i < 8) c[2:0] = i[2:0];
      if (i == 8) c = 7'h18;
      m = c[2:0];
      {frm_sync, sck, rst_e, eng_do} <= seed[13:7];
      bus(1'b1, `CFG_ONE_ADDR, {25'h0, c});
      // one cycle after the write edge the new map must stand
      @(negedge ref_clk);
      `CHK("oe", exp_oe(c), dev_oe)
      if (m != 3'h0) `CHK("dout", eng_do[0], dev_o[`PIN_DOUT])
      if (m != 3'h0) `CHK("sync", frm_sync, dev_o[`PIN_SYNC])
      if (m == 3'h1 || m >= 3'h4) `CHK("sclk", sck, dev_o[`PIN_SCLK])
      if (m >= 3'h1 && m <= 3'h3) `CHK("rst", rst_e, dev_o[`PIN_RST])
      if (m == 3'h1) `CHK("flag", c[6], dev_o[`PIN_AUX])
      if (m == 3'h4 || m == 3'h7) `CHK("i2s_din", eng_do[2:1], {dev_o[`PIN_RST], dev_o[`PIN_DIN]})
      if (m == 3'h5) `CHK("i2s_dout2", eng_do[1], dev_o[`PIN_DIN])
      if (m == 3'h7) `CHK("i2s_dout4", eng_do[3], dev_o[`PIN_AUX])
      if (m == 3'h0 || m == 3'h2) `CHK("nc_aux", 1'b0, dev_o[`PIN_AUX])
      @(posedge ref_clk);
      run <= 1'b1;
      repeat (16) @(posedge ref_clk);
      run <= 1'b0;
      repeat (12) @(posedge ref_clk);
      `CHK("in0", exp_in(m, wire_v), din_e)
      if (m == 3'h3 || m == 3'h5) `CHK("in1", exp_in(m, wire_v) & 3'h2, din_e & 3'h2)
      if (m == 3'h6) `CHK("in_all", exp_in(m, wire_v), din_e)
    end
    seed = lfsr(seed);
    bus(1'b1, `CFG_ONE_ADDR, 32'h18);
    bus(1'b1, `GP_PIN_ADDR, {27'h0, seed[4:0]});
    repeat (6) @(posedge ref_clk);
    `CHK("gp_pins", {seed[4], seed[2:0]}, {dev_o[`PIN_RST], dev_o[`PIN_DOUT], dev_o[`PIN_SCLK], dev_o[`PIN_SYNC]})
    bus(1'b0, `GP_PIN_ADDR, 32'h0);
    `CHK("gp_rd", {wire_v, 3'h0, seed[4:0]}, q[13:0])
    for (int j = 0; j < 3; j++) begin
      seed = lfsr(seed);
      f = (j == 0) ? 24'h400000 : (j == 1) ? 24'h100000 : 24'h40000 + 24'(seed % 32'h700000);
      bus(1'b1, `ADAPT_FREQ_ADDR, {8'h0, f});
      bus(1'b1, `CFG_ONE_ADDR, 32'h2);
      run <= 1'b1;
      count(640);
      `CHK("adapt_rate", 1'b1, near(cnt[3], (64'(f) * 640) >> 24))
      `CHK("mclk_adaptive", 1'b1, near(cnt[2], cnt[3]))
      `CHK("bclk_rise", 1'b1, near(cnt[4], cnt[0]))
      bus(1'b0, `ADAPT_MEAS_ADDR, 32'h0);
      `CHK("meas", 1'b1, near(q[15:0], (64'(f) * 64) >> 24))
      bus(1'b1, `CFG_ONE_ADDR, 32'h22);
      count(640);
      `CHK("mclk_ext", 1'b1, near(cnt[2], cnt[1]))
      run <= 1'b0;
    end
    final_report;
  end
endmodule
